// File: src/psrc_top.sv
`timescale 1ns/1ns
`default_nettype none
`include "psrc_defines.svh"
module psrc_top (
    // clock, reset, enable
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_ce,
    // register port
    input wire logic [11:0] i_addr,
    input wire logic [31:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [31:0] o_rdata,
    // device capabilities
    input wire logic [31:0] i_capability_mask_two,
    input wire logic [31:0] i_capability_mask_four,
    // unit reset controls
    output logic [31:0] o_periph_reset,
    output logic [7:0] o_io_port_reset
);

    psrc_pkg::psrc_state_s s_q;
    psrc_pkg::psrc_state_s s_d;

    // ------------------------------------------------------------------------
    // next state
    // ------------------------------------------------------------------------
    // masks make bits of absent units keep their old value and keep reserved bits at their reset zero
    always_comb begin
        s_d = s_q;
        s_d.rdata = 32'h00000000;
        if (i_wr && i_addr == `PSRC_OFS_RST_ONE) begin
            s_d.rst_one = (s_q.rst_one & ~(i_capability_mask_two
                & `PSRC_ONE_RW_MASK)) | (i_wdata & i_capability_mask_two
                & `PSRC_ONE_RW_MASK);
        end
        if (i_wr && i_addr == `PSRC_OFS_RST_PORT) begin
            s_d.rst_port = (s_q.rst_port & ~(i_capability_mask_four
                & `PSRC_PORT_RW_MASK)) | (i_wdata & i_capability_mask_four
                & `PSRC_PORT_RW_MASK);
        end
        // unmapped reads return zero
        if (i_rd) begin
            unique case (i_addr)
                `PSRC_OFS_RST_ONE: s_d.rdata = s_q.rst_one;
                `PSRC_OFS_RST_PORT: s_d.rdata = s_q.rst_port;
                default: s_d.rdata = 32'h00000000;
            endcase
        end
    end

    // state register; enable low freezes everything
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            s_q <= '0;
        end else if (i_ce) begin
            s_q <= s_d;
        end
    end

    // outputs straight from flops
    assign o_rdata = s_q.rdata;
    assign o_periph_reset = s_q.rst_one;
    assign o_io_port_reset = s_q.rst_port[7:0];

    // ------------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------------
    AST_ONE_MASKED: assert property (
        @(posedge i_clk) disable iff (!i_rst_n)
        i_ce && i_wr && i_addr == `PSRC_OFS_RST_ONE |=>
        ((o_periph_reset ^ $past(o_periph_reset))
         & ~$past(i_capability_mask_two)) == 32'h00000000)
        else $error("masked bit of first reset register changed");
    AST_PORT_MASKED: assert property (
        @(posedge i_clk) disable iff (!i_rst_n)
        i_ce && i_wr && i_addr == `PSRC_OFS_RST_PORT |=>
        ((o_io_port_reset ^ $past(o_io_port_reset))
         & ~$past(i_capability_mask_four[7:0])) == 8'h00)
        else $error("masked port reset bit changed");
    AST_RESET_ZERO: assert property (
        @(posedge i_clk)
        !i_rst_n |-> o_periph_reset == 32'h00000000 && o_io_port_reset == 8'h00)
        else $error("reset controls not zero in reset");
    AST_RESERVED_ZERO: assert property (
        @(posedge i_clk) disable iff (!i_rst_n)
        (o_periph_reset & ~`PSRC_ONE_RW_MASK) == 32'h00000000)
        else $error("reserved bit set");
    AST_SERIAL_WRITE: assert property (
        @(posedge i_clk) disable iff (!i_rst_n)
        i_ce && i_wr && i_addr == `PSRC_OFS_RST_ONE
        && i_capability_mask_two[2:0] == 3'h7 |=>
        o_periph_reset[2:0] == $past(i_wdata[2:0]))
        else $error("serial port reset bits not written");
    AST_PORT_WRITE: assert property (
        @(posedge i_clk) disable iff (!i_rst_n)
        i_ce && i_wr && i_addr == `PSRC_OFS_RST_PORT
        && i_capability_mask_four[7:0] == 8'hFF |=>
        o_io_port_reset == $past(i_wdata[7:0]))
        else $error("port reset bits not written");
    AST_HOLD: assert property (
        @(posedge i_clk) disable iff (!i_rst_n)
        !(i_ce && i_wr) |=> $stable(o_periph_reset)
        && $stable(o_io_port_reset))
        else $error("reset control changed without write");
    AST_READ_ONE: assert property (
        @(posedge i_clk) disable iff (!i_rst_n)
        i_ce && i_rd && i_addr == `PSRC_OFS_RST_ONE |=>
        o_rdata == $past(o_periph_reset))
        else $error("read data mismatch");
    AST_READ_PORT: assert property (
        @(posedge i_clk) disable iff (!i_rst_n)
        i_ce && i_rd && i_addr == `PSRC_OFS_RST_PORT |=>
        o_rdata == {24'h000000, $past(o_io_port_reset)})
        else $error("port read data mismatch");
    COV_FREEZE: cover property (@(posedge i_clk)
        !i_ce && i_wr);
    COV_ONE_WR: cover property (@(posedge i_clk)
        i_ce && i_wr && i_addr == `PSRC_OFS_RST_ONE);
    COV_PORT_WR: cover property (@(posedge i_clk)
        i_ce && i_wr && i_addr == `PSRC_OFS_RST_PORT);
    COV_RELEASE: cover property (@(posedge i_clk)
        o_io_port_reset[0] ##1 !o_io_port_reset[0]);

endmodule // psrc_top
`default_nettype wire

// File: src/psrc_defines.svh
`ifndef PSRC_DEFINES_SVH
`define PSRC_DEFINES_SVH

// ----------------------------------------------------------------------------
// register map
// ----------------------------------------------------------------------------
`define PSRC_ADDR_W 12
`define PSRC_OFS_RST_ONE 12'h044
`define PSRC_OFS_RST_PORT 12'h048
`define PSRC_RST_VAL 32'h00000000

// ----------------------------------------------------------------------------
// writable field masks (all other bits reserved)
// ----------------------------------------------------------------------------
`define PSRC_ONE_RW_MASK 32'h070F1137
`define PSRC_PORT_RW_MASK 32'h000000FF
`define PSRC_SERIAL_LSB 0
`define PSRC_SERIAL_W 3
`define PSRC_PORT_W 8

`endif

// File: src/psrc_pkg.sv
package psrc_pkg;
    // all state of the reset control block
    typedef struct packed {
        logic [31:0] rst_one;
        logic [31:0] rst_port;
        logic [31:0] rdata;
    } psrc_state_s;
endpackage

// File: verif/psrc_top_test.sv
`timescale 1ns/1ns
`default_nettype none
`include "psrc_defines.svh"
module psrc_top_test;
    // -----------------------------------------------------------------
    // register port stimulus with read notes checked by a monitor
    // -----------------------------------------------------------------
    logic i_clk = 0, i_rst_n = 0, i_wr = 0, i_rd = 0, p = 0;
    logic i_ce = 1, fz = 0;
    logic [11:0] i_addr = 12'h000;
    logic [31:0] i_wdata = 32'h0, mk2 = 32'h0, mk4 = 32'h0, m1 = 32'h0;
    logic [31:0] m2 = 32'h0, r = 32'h000174AF, o_rdata, o_periph_reset;
    logic [7:0] o_io_port_reset;
    logic [33:0] note, q[$];
    int fail_count = 0, check_count = 0;
    psrc_top dut (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_ce(i_ce),
        .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
        .o_rdata(o_rdata), .i_capability_mask_two(mk2),
        .i_capability_mask_four(mk4), .o_periph_reset(o_periph_reset),
        .o_io_port_reset(o_io_port_reset));
    initial forever #20 i_clk = ~i_clk;
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic chk(input string n, input logic [31:0] e, logic [31:0] g);
        check_count++;
        if (g !== e) begin
            fail_count++;
            $display("Error %s expected %h seen %h", n, e, g);
        end
    endtask
    // masked bits keep their old value, so the model merges under the mask
    task automatic acc(input logic w, logic [11:0] a, logic [31:0] d, int k);
        @(posedge i_clk);
        i_wr <= w;
        i_rd <= !w;
        i_addr <= a;
        i_wdata <= d;
        i_ce <= !fz;
        // enable low freezes the block, so a frozen write leaves the model
        if (w && !fz && a == 12'h044)
            m1 = (m1 & ~(mk2 & `PSRC_ONE_RW_MASK))
                | (d & mk2 & `PSRC_ONE_RW_MASK);
        if (w && !fz && a == 12'h048)
            m2 = (m2 & ~(mk4 & 32'hFF)) | (d & mk4 & 32'hFF);
        if (!w) q.push_back({k[1:0], a == 12'h044 ? m1 : a == 12'h048 ? m2 : 32'h0});
    endtask
    task automatic results;
        $display("checks %0d errors %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    // read data stands only in the cycle after the strobe
    always @(posedge i_clk) begin
        p <= i_rd;
        if (p) begin
            note = q.pop_front();
            chk("rdata", note[31:0], o_rdata);
            if (note[32]) chk("periph", note[31:0], o_periph_reset);
            if (note[33]) chk("ports", note[31:0], {24'h0, o_io_port_reset});
        end
    end
    initial begin
        repeat (8) @(posedge i_clk);
        i_rst_n <= 1;
        for (int i = 0; i < 14; i++) begin
            acc(0, 12'h044, 0, 1);
            acc(0, 12'h048, 0, 2);
            acc(0, 12'h04C, 0, 0);
            @(posedge i_clk);
            i_rd <= 0;
            r = lfsr(r);
            mk2 <= (i < 2) ? 32'hFFFFFFFF : r;
            r = lfsr(r);
            mk4 <= (i < 2) ? 32'hFFFFFFFF : r;
            r = lfsr(r);
            fz = (i == 5);
            acc(1, 12'h044, r, 0);
            acc(1, 12'h048, ~r, 0);
            acc(1, 12'h04C, r, 0);
            fz = 0;
            // a reset in mid-run must clear both registers again
            if (i == 9) begin
                i_rst_n <= 0;
                m1 = 32'h0;
                m2 = 32'h0;
                @(posedge i_clk);
                i_rst_n <= 1;
            end
        end
        acc(0, 12'h044, 0, 1);
        acc(0, 12'h048, 0, 2);
        @(posedge i_clk);
        i_rd <= 0;
        for (int n = 0; n < 10 && q.size() > 0; n++) @(posedge i_clk);
        if (q.size() > 0) fail_count++;
        results();
    end
endmodule // psrc_top_test
`default_nettype wire
